// *** qdr_chan_mem.sv ***
// qdr_chan_mem: channel word store, one write port and two registered read ports
`timescale 1ns/10ps
`default_nettype none
module qdr_chan_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 12,
  parameter int AW = 3
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write index
  input wire logic [WIDTH-1:0] wdata, // write word
  input wire logic [(WIDTH+7)/8-1:0] wbe, // byte lane enables
  input wire logic [AW-1:0] raddr_a, // read index, port a
  output logic [WIDTH-1:0] rdata_a, // registered read data, port a
  input wire logic [AW-1:0] raddr_b, // read index, port b
  output logic [WIDTH-1:0] rdata_b // registered read data, port b
);
  logic [WIDTH-1:0] mem [DEPTH];

  // words clear at reset so the outputs read zero until loaded
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (we) begin
      for (int b = 0; b < WIDTH; b++) begin
        if (wbe[b/8]) begin
          mem[waddr][b] <= wdata[b];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule : qdr_chan_mem
`default_nettype wire

// *** qdr_master.sv ***
// qdr_master: behavioural two-wire bus master
`timescale 1ns/10ps
`default_nettype none
module qdr_master (
  output logic scl_m, // clock release
  output logic sda_m, // data release
  input wire logic scl_i, // resolved clock
  input wire logic sda_i // resolved data
);
  // quarter bit, well above the device's synchroniser delay
  localparam realtime Q = 200.0;
  initial begin
    scl_m = 1'h1;
    sda_m = 1'h1;
  end
  // waiting on the pin lets the device stretch the clock
  task automatic bitx(input logic b, output logic r);
    #Q sda_m = b;
    #Q scl_m = 1'h1;
    wait (scl_i === 1'h1);
    #(2 * Q) r = sda_i;
    scl_m = 1'h0;
  endtask : bitx
  // start or repeated start when stp is low, stop otherwise
  task automatic cond(input logic stp);
    #Q sda_m = ~stp;
    #Q scl_m = 1'h1;
    wait (scl_i === 1'h1);
    #Q sda_m = stp;
    #Q scl_m = stp;
  endtask : cond
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'h1, r);
    ack = ~r;
  endtask : put
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'h1, b[i]);
    bitx(last, r);
  endtask : get
endmodule : qdr_master
`default_nettype wire

// *** qdr_pkg.sv ***
// qdr_pkg: shared constants and types of the quad converter readback block
package qdr_pkg;
  // register map, byte addresses on the AXI4-Lite bus
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TEMP_BASE = 8'h10;
  localparam logic [7:0] REG_OUT_BASE = 8'h20;
  localparam logic [7:0] CHAN_SPAN = 8'h10;
  localparam int WORD_SHIFT = 2;
  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  // status register fields
  localparam int STAT_CB_LSB = 0;
  localparam int STAT_SEEN_BIT = 8;
  localparam int STAT_CNT_LSB = 16;
  localparam int STAT_CNT_W = 8;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // serial link constants
  localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h13;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CB_PD_BIT = 0;
  localparam int CB_SEL_LSB = 1;
  localparam logic [1:0] BYTES_WITH_PD = 2'h3;
  localparam logic [1:0] BYTES_NO_PD = 2'h2;
  // channel word layout: mode bits on top, code below
  localparam int WORD_W = 12;
  localparam int MODE_HI = 11;
  localparam int MODE_LO = 10;
  localparam int CODE_HI = 9;
  localparam int CODE_HB_LO = 2;
  localparam int CODE_LB_HI = 1;
  localparam logic [5:0] PD_BYTE_FILL = 6'h3f;
  localparam logic [5:0] LOW_BYTE_FILL = 6'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
  // link state machine
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_CTRL, LK_ACK, LK_WAIT, LK_TX, LK_MACK
  } qdr_link_state_t;
  typedef enum logic [1:0] {AK_TO_CTRL, AK_TO_IDLE, AK_TO_READ} qdr_ack_next_t;
endpackage : qdr_pkg

// *** qdr_properties.sv ***
// qdr_properties: port checks of the readback block
`timescale 1ns/10ps
`default_nettype none
module qdr_properties (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic link_clk, // link clock
  input wire logic scl_i, // clock pin
  input wire logic scl_oe, // clock hold
  input wire logic sda_o, // data value
  input wire logic sda_oe, // data pull
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid // r valid
);
  wr_busy_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_bvalid |-> !s_axi_awready) else $error("write taken while busy");
  rd_busy_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  rd_lat_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid) else $error("read late");
  open_drain_a: assert property (@(posedge link_clk) disable iff (rst) !sda_o)
    else $error("data driven high");
  data_move_a: assert property (@(posedge link_clk) disable iff (rst)
    $changed(sda_oe) |-> !scl_i) else $error("data moved with clock high");
  hold_start_a: assert property (@(posedge link_clk) disable iff (rst)
    $rose(scl_oe) |-> !$past(scl_i)) else $error("clock held while high");
  hold_len_a: assert property (@(posedge link_clk) disable iff (rst)
    $rose(scl_oe) |-> ##[1:20] !scl_oe) else $error("clock held too long");
  hold_end_a: assert property (@(posedge link_clk) disable iff (rst)
    $fell(scl_oe) |-> $stable(sda_oe)) else $error("bit not set before release");
endmodule : qdr_properties
bind qdr_readback qdr_properties qdr_properties_i (.clk, .rst, .link_clk, .scl_i, .scl_oe,
  .sda_o, .sda_oe, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// *** qdr_readback.sv ***
// qdr_readback: serial-link slave transmitter for channel readback, with AXI4-Lite registers
// Functional notes
// - on address match the device pulls data low in the acknowledge clock
// - control byte holds load, channel select and power-down flag; device acknowledges
// - device acknowledges read address, then drives data line with readback bytes
// - returned word is the channel chosen by the latest control byte
// - flag clear gives two bytes: high data byte then low data byte
// - flag set gives three bytes: power-down byte, high byte, low byte
// - high byte carries code bits nine to two, bit nine first
// - low byte carries code bits one and zero on top, rest don't care
// - power-down byte has both mode bits on top, six ones below
// - high-speed mode uses the same address and same readback sequence
// - mode bits pick output state: open, one kilo-ohm, hundred kilo-ohm, open
// - each channel has temp and output words, twelve bits, mode on top
// - nobody acknowledges the high-speed master code
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module qdr_readback #(
  parameter int CHAN_N = 4,
  parameter int CH_W = 2
) (
  input wire logic clk, // system clock, 250 MHz
  input wire logic rst, // async reset, active high
  input wire logic link_clk, // sampling clock of the serial link
  input wire logic scl_i, // serial clock pin level
  output logic scl_o, // serial clock drive value, always low
  output logic scl_oe, // high while holding serial clock low
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive value, always low
  output logic sda_oe, // high while pulling serial data low
  input wire logic slave_addr_pin_hi, // address strap, upper
  input wire logic slave_addr_pin_lo, // address strap, lower
  input wire logic [qdr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [qdr_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  localparam int MEM_AW = CH_W + 1;
  localparam int W = qdr_pkg::WORD_W;

  // ---------------- register side (clk) ----------------
  logic [qdr_pkg::AXI_ADDR_W-1:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic wr_go;
  logic [qdr_pkg::AXI_ADDR_W-1:0] ar_addr_reg;
  logic rd_wait_reg;
  logic en_reg;
  logic [7:0] cb_stat_reg;
  logic seen_reg;
  logic [qdr_pkg::STAT_CNT_W-1:0] fetch_cnt_reg;
  logic [W-1:0] rdata_a;
  logic [W-1:0] rdata_b;
  logic [W-1:0] held_word_reg;
  logic fetch_ack_tgl_reg;
  logic req_m_reg, req_s_reg, req_d_reg;
  logic fetch_busy_reg;
  logic cb_m_reg, cb_s_reg, cb_d_reg;

  // channel words live at temp index ch and output index CHAN_N + ch
  function automatic logic is_chan(input logic [qdr_pkg::AXI_ADDR_W-1:0] a);
    is_chan = (a >= qdr_pkg::REG_TEMP_BASE) &&
      (a < qdr_pkg::REG_OUT_BASE + qdr_pkg::CHAN_SPAN) &&
      (a[qdr_pkg::WORD_SHIFT-1:0] == '0);
  endfunction : is_chan

  function automatic logic [MEM_AW-1:0] chan_idx(input logic [qdr_pkg::AXI_ADDR_W-1:0] a);
    logic [qdr_pkg::AXI_ADDR_W-1:0] off;
    off = a - qdr_pkg::REG_TEMP_BASE;
    chan_idx = MEM_AW'(off >> qdr_pkg::WORD_SHIFT);
  endfunction : chan_idx

  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // write path: address and data taken in either order, answer after both
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= qdr_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (is_chan(aw_addr_reg) || aw_addr_reg == qdr_pkg::REG_CTRL) ?
          qdr_pkg::RESP_OKAY : qdr_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // enable gates whether the link answers its address at all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_reg <= qdr_pkg::CTRL_EN_RESET;
    end else if (wr_go && aw_addr_reg == qdr_pkg::REG_CTRL && w_strb_reg[0]) begin
      en_reg <= w_data_reg[qdr_pkg::CTRL_EN_BIT];
    end
  end

  // read path: one cycle spent in the registered memory port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      ar_addr_reg <= '0;
      rd_wait_reg <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= qdr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_addr_reg <= s_axi_araddr;
      s_axi_arready <= 1'b0;
      rd_wait_reg <= 1'b1;
    end else if (rd_wait_reg) begin
      rd_wait_reg <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= qdr_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
      if (is_chan(ar_addr_reg)) begin
        s_axi_rdata[W-1:0] <= rdata_a;
      end else if (ar_addr_reg == qdr_pkg::REG_CTRL) begin
        s_axi_rdata[qdr_pkg::CTRL_EN_BIT] <= en_reg;
      end else if (ar_addr_reg == qdr_pkg::REG_STATUS) begin
        s_axi_rdata[qdr_pkg::STAT_CB_LSB +: 8] <= cb_stat_reg;
        s_axi_rdata[qdr_pkg::STAT_SEEN_BIT] <= seen_reg;
        s_axi_rdata[qdr_pkg::STAT_CNT_LSB +: qdr_pkg::STAT_CNT_W] <= fetch_cnt_reg;
      end else begin
        s_axi_rresp <= qdr_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- link side (link_clk) ----------------
  logic scl_m_reg, scl_s_reg, scl_d_reg;
  logic sda_m_reg, sda_s_reg, sda_d_reg;
  logic [1:0] pin_m_reg, pin_s_reg;
  logic en_m_reg, en_s_reg;
  logic ack_m_reg, ack_s_reg, ack_d_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop, fetch_done;
  qdr_pkg::qdr_link_state_t lk_state_reg;
  qdr_pkg::qdr_ack_next_t ack_next_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic [CH_W-1:0] sel_reg;
  logic [CH_W-1:0] fetch_ch_reg;
  logic pd_reg;
  logic fetch_req_tgl_reg;
  logic data_ok_reg;
  logic [W-1:0] snap_reg;
  logic [1:0] byte_idx_reg;
  logic more_reg;
  logic [7:0] cb_byte_reg;
  logic cb_tgl_reg;

  // picks the readback byte in sequence order for the current flag
  function automatic logic [7:0] rb_byte(input logic [W-1:0] w, input logic pd,
                                         input logic [1:0] idx);
    logic [1:0] k;
    k = pd ? idx : 2'(idx + 2'h1);
    unique case (k)
      2'h0: rb_byte = {w[qdr_pkg::MODE_HI:qdr_pkg::MODE_LO], qdr_pkg::PD_BYTE_FILL};
      // high byte, code bit nine first
      2'h1: rb_byte = w[qdr_pkg::CODE_HI:qdr_pkg::CODE_HB_LO];
      // low byte, two code bits on top
      default: rb_byte = {w[qdr_pkg::CODE_LB_HI:0], qdr_pkg::LOW_BYTE_FILL};
    endcase
  endfunction : rb_byte

  logic [7:0] first_byte, next_byte;
  assign first_byte = rb_byte(snap_reg, pd_reg, byte_idx_reg);
  assign next_byte = rb_byte(snap_reg, pd_reg, 2'(byte_idx_reg + 2'h1));

  // pins and straps pass two flops before anything looks at them
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      pin_m_reg <= '0;
      pin_s_reg <= '0;
      en_m_reg <= 1'b0;
      en_s_reg <= 1'b0;
      ack_m_reg <= 1'b0;
      ack_s_reg <= 1'b0;
      ack_d_reg <= 1'b0;
    end else begin
      scl_m_reg <= scl_i;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
      pin_m_reg <= {slave_addr_pin_hi, slave_addr_pin_lo};
      pin_s_reg <= pin_m_reg;
      en_m_reg <= en_reg;
      en_s_reg <= en_m_reg;
      ack_m_reg <= fetch_ack_tgl_reg;
      ack_s_reg <= ack_m_reg;
      ack_d_reg <= ack_s_reg;
    end
  end

  assign scl_rise = scl_s_reg && !scl_d_reg;
  assign scl_fall = !scl_s_reg && scl_d_reg;
  // start and repeated start both seen as data falling under high clock
  assign bus_start = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
  assign bus_stop = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;
  assign fetch_done = ack_s_reg ^ ack_d_reg;

  // frame engine, same sequence for every bus speed
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_state_reg <= qdr_pkg::LK_IDLE;
      ack_next_reg <= qdr_pkg::AK_TO_IDLE;
      sh_reg <= '0;
      cnt_reg <= '0;
      sel_reg <= '0;
      pd_reg <= 1'b0;
      fetch_ch_reg <= '0;
      fetch_req_tgl_reg <= 1'b0;
      byte_idx_reg <= '0;
      more_reg <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      cb_byte_reg <= '0;
      cb_tgl_reg <= 1'b0;
    end else if (bus_start) begin
      lk_state_reg <= qdr_pkg::LK_ADDR;
      cnt_reg <= '0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (bus_stop) begin
      lk_state_reg <= qdr_pkg::LK_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      unique case (lk_state_reg)
        qdr_pkg::LK_IDLE: begin
          sda_oe <= 1'b0;
          scl_oe <= 1'b0;
        end
        qdr_pkg::LK_ADDR, qdr_pkg::LK_CTRL: begin
          if (scl_rise && cnt_reg != qdr_pkg::BITS_PER_BYTE) begin
            sh_reg <= {sh_reg[6:0], sda_s_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == qdr_pkg::BITS_PER_BYTE) begin
            if (lk_state_reg == qdr_pkg::LK_CTRL) begin
              // keep select and flag, acknowledge the control byte
              sel_reg <= sh_reg[qdr_pkg::CB_SEL_LSB +: CH_W];
              pd_reg <= sh_reg[qdr_pkg::CB_PD_BIT];
              cb_byte_reg <= sh_reg;
              cb_tgl_reg <= !cb_tgl_reg;
              sda_oe <= 1'b1;
              ack_next_reg <= qdr_pkg::AK_TO_IDLE;
              lk_state_reg <= qdr_pkg::LK_ACK;
            end else if (en_s_reg &&
                         sh_reg[7:1] == {qdr_pkg::SLAVE_ADDR_FIXED, pin_s_reg}) begin
              // address match, pull data low through the acknowledge clock
              sda_oe <= 1'b1;
              lk_state_reg <= qdr_pkg::LK_ACK;
              if (sh_reg[0] == qdr_pkg::RW_READ) begin
                // snapshot of the selected channel requested at this acknowledge
                fetch_ch_reg <= sel_reg;
                fetch_req_tgl_reg <= !fetch_req_tgl_reg;
                ack_next_reg <= qdr_pkg::AK_TO_READ;
              end else begin
                ack_next_reg <= qdr_pkg::AK_TO_CTRL;
              end
            end else begin
              // master code and foreign addresses are left unanswered
              lk_state_reg <= qdr_pkg::LK_IDLE;
            end
          end
        end
        qdr_pkg::LK_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            cnt_reg <= '0;
            byte_idx_reg <= '0;
            unique case (ack_next_reg)
              qdr_pkg::AK_TO_CTRL: lk_state_reg <= qdr_pkg::LK_CTRL;
              // hold clock low until the snapshot is in, then transmit
              qdr_pkg::AK_TO_READ: begin
                scl_oe <= 1'b1;
                lk_state_reg <= qdr_pkg::LK_WAIT;
              end
              default: lk_state_reg <= qdr_pkg::LK_IDLE;
            endcase
          end
        end
        qdr_pkg::LK_WAIT: begin
          if (data_ok_reg) begin
            sh_reg <= first_byte;
            sda_oe <= !first_byte[7];
            cnt_reg <= 4'h1;
            lk_state_reg <= qdr_pkg::LK_TX;
          end
        end
        qdr_pkg::LK_TX: begin
          // data settles one sample before the clock is let go
          scl_oe <= 1'b0;
          if (scl_fall) begin
            if (cnt_reg == qdr_pkg::BITS_PER_BYTE) begin
              sda_oe <= 1'b0;
              more_reg <= 1'b0;
              lk_state_reg <= qdr_pkg::LK_MACK;
            end else begin
              sh_reg <= {sh_reg[6:0], 1'b0};
              sda_oe <= !sh_reg[6];
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        qdr_pkg::LK_MACK: begin
          if (scl_rise) begin
            // three bytes with it; a refusal ends the burst early
            more_reg <= !sda_s_reg &&
              (byte_idx_reg != 2'(((pd_reg) ? qdr_pkg::BYTES_WITH_PD :
                                              qdr_pkg::BYTES_NO_PD) - 2'h1));
            if (sda_s_reg) begin
              lk_state_reg <= qdr_pkg::LK_IDLE;
            end
          end else if (scl_fall) begin
            if (more_reg) begin
              sh_reg <= next_byte;
              sda_oe <= !next_byte[7];
              byte_idx_reg <= 2'(byte_idx_reg + 2'h1);
              cnt_reg <= 4'h1;
              lk_state_reg <= qdr_pkg::LK_TX;
            end else begin
              // past the last byte the line stays released for stop or restart
              lk_state_reg <= qdr_pkg::LK_IDLE;
            end
          end
        end
        default: lk_state_reg <= qdr_pkg::LK_IDLE;
      endcase
    end
  end

  // snapshot word of the selected channel, held as is; data_ok_reg drops during every address byte
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      data_ok_reg <= 1'b0;
      snap_reg <= qdr_pkg::WORD_RESET;
    end else if (fetch_done) begin
      data_ok_reg <= 1'b1;
      snap_reg <= held_word_reg;
    end else if (lk_state_reg == qdr_pkg::LK_ADDR) begin
      data_ok_reg <= 1'b0;
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ---------------- crossings into the register side ----------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_m_reg <= 1'b0;
      req_s_reg <= 1'b0;
      req_d_reg <= 1'b0;
      cb_m_reg <= 1'b0;
      cb_s_reg <= 1'b0;
      cb_d_reg <= 1'b0;
    end else begin
      req_m_reg <= fetch_req_tgl_reg;
      req_s_reg <= req_m_reg;
      req_d_reg <= req_s_reg;
      cb_m_reg <= cb_tgl_reg;
      cb_s_reg <= cb_m_reg;
      cb_d_reg <= cb_s_reg;
    end
  end

  // fetch: channel index is stable well before its toggle arrives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_busy_reg <= 1'b0;
      held_word_reg <= qdr_pkg::WORD_RESET;
      fetch_ack_tgl_reg <= 1'b0;
      fetch_cnt_reg <= '0;
    end else if (req_s_reg ^ req_d_reg) begin
      fetch_busy_reg <= 1'b1;
    end else if (fetch_busy_reg) begin
      fetch_busy_reg <= 1'b0;
      held_word_reg <= rdata_b;
      fetch_ack_tgl_reg <= !fetch_ack_tgl_reg;
      fetch_cnt_reg <= fetch_cnt_reg + 8'h01;
    end
  end

  // last control byte for software; byte is stable once its toggle lands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cb_stat_reg <= '0;
      seen_reg <= 1'b0;
    end else if (cb_s_reg ^ cb_d_reg) begin
      cb_stat_reg <= cb_byte_reg;
      seen_reg <= 1'b1;
    end
  end

  // temp and output words per channel, mode bits above the code
  // mode bits are kept as stored; the analog side decodes them
  qdr_chan_mem #(
    .DEPTH(2 * CHAN_N),
    .WIDTH(W),
    .AW(MEM_AW)
  ) u_mem (
    .clk(clk),
    .rst(rst),
    .we(wr_go && is_chan(aw_addr_reg)),
    .waddr(chan_idx(aw_addr_reg)),
    .wdata(w_data_reg[W-1:0]),
    .wbe(w_strb_reg[1:0]),
    .raddr_a(chan_idx(s_axi_araddr)),
    .rdata_a(rdata_a),
    .raddr_b({1'b1, fetch_ch_reg}),
    .rdata_b(rdata_b)
  );
endmodule : qdr_readback
`default_nettype wire

// *** qdr_readback_tb.sv ***
// qdr_readback_tb: self-checking bench of the readback block
`timescale 1ns/10ps
`default_nettype none
module qdr_readback_tb;
  localparam logic [6:0] ADDR = {qdr_pkg::SLAVE_ADDR_FIXED, 2'h2};
  logic clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst = 1'h1;
  logic scl_m, sda_m, scl_oe, sda_oe, scl_i, sda_i, scl_o, sda_o;
  logic [1:0] strap = 2'h2;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] wtab [4] = '{12'h3a5, 12'h55a, 12'h9c3, 12'hc01};
  int err_total = 0;
  int n_compared = 0;
  // pull-ups: a line is high unless someone pulls it low
  assign scl_i = scl_m & (~scl_oe | scl_o);
  assign sda_i = sda_m & (~sda_oe | sda_o);
  always #2 clk = ~clk;
  initial begin
    #1.3;
    forever #32 link_clk = ~link_clk;
  end
  qdr_readback qdr_readback_i (.clk, .rst, .link_clk, .scl_i, .scl_o, .scl_oe, .sda_i,
    .sda_o, .sda_oe, .slave_addr_pin_hi(strap[1]), .slave_addr_pin_lo(strap[0]), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  qdr_master qdr_master_i (.scl_m, .sda_m, .scl_i, .sda_i);
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask : check
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    check(32'(s_axi_bresp), 32'(r));
    s_axi_bready <= 1'h0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    check(s_axi_rdata, e);
    check(32'(s_axi_rresp), 32'(r));
    s_axi_rready <= 1'h0;
  endtask : axi_rd
  task automatic t_axi();
    axi_rd(qdr_pkg::REG_CTRL, 32'(qdr_pkg::CTRL_EN_RESET), 2'h0);
    for (int k = 0; k < 4; k++) axi_wr(qdr_pkg::REG_OUT_BASE + 8'(4 * k), 32'(wtab[k]), 2'h0);
    s_axi_wstrb <= 4'h1;
    axi_wr(qdr_pkg::REG_OUT_BASE, 32'hfa5, 2'h0);
    s_axi_wstrb <= 4'hf;
    axi_rd(qdr_pkg::REG_OUT_BASE + 8'h8, 32'(wtab[2]), 2'h0);
    axi_wr(qdr_pkg::REG_STATUS, 32'h0, 2'h2);
    axi_rd(8'h08, 32'h0, 2'h2);
  endtask : t_axi
  task automatic t_rb(input logic [1:0] ch, input logic pd, input logic hs);
    logic ak;
    logic [7:0] b [3];
    int n;
    n = pd ? 3 : 2;
    if (hs) begin
      qdr_master_i.cond(1'h0);
      qdr_master_i.put(8'h08, ak);
      check(32'(ak), 32'h0);
    end
    qdr_master_i.cond(1'h0);
    qdr_master_i.put({ADDR, 1'h0}, ak);
    check(32'(ak), 32'h1);
    qdr_master_i.put({5'h0, ch, pd}, ak);
    check(32'(ak), 32'h1);
    qdr_master_i.cond(1'h0);
    qdr_master_i.put({ADDR, qdr_pkg::RW_READ}, ak);
    check(32'(ak), 32'h1);
    for (int i = 0; i < n; i++) qdr_master_i.get(i == n - 1, b[i]);
    qdr_master_i.cond(1'h1);
    if (pd) check(32'(b[0]), 32'({wtab[ch][11:10], 6'h3f}));
    check(32'(b[n - 2]), 32'(wtab[ch][9:2]));
    check(32'(b[n - 1][7:6]), 32'(wtab[ch][1:0]));
  endtask : t_rb
  task automatic t_refuse();
    logic ak;
    qdr_master_i.cond(1'h0);
    qdr_master_i.put({ADDR ^ 7'h01, 1'h0}, ak);
    check(32'(ak), 32'h0);
    qdr_master_i.cond(1'h1);
  endtask : t_refuse
  task automatic t_status();
    // last control byte, seen flag, five fetches
    axi_rd(qdr_pkg::REG_STATUS, 32'h0005_0104, 2'h0);
  endtask : t_status
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge link_clk);
    t_axi();
    for (int k = 0; k < 4; k++) t_rb(2'(k), 1'h1, k == 1);
    t_rb(2'h2, 1'h0, 1'h0);
    t_refuse();
    t_status();
    final_report();
  end
  initial begin
    #380us;
    err_total++;
    final_report();
  end
endmodule : qdr_readback_tb
`default_nettype wire
